//--- hw/ifu_alu.v
// Single precision float ALU with gradual underflow, rounding and flags
// Function
// - single words: sign 31, exponent bias 127 at 30..23, fraction 22..0
// - double words: sign 63, exponent bias 1023 at 62..52, fraction 51..0
// - arithmetic on single precision only; double only moved
// - extended values live only in registers; results stored single or double (no extended format here: results are single, double is only moved)
// - encodings for signed zero, signed infinity, denormals, quiet and signaling Not_a_number_value
// - underflow when normalized result exponent falls below format minimum
// - gradual mode shifts mantissa right until exponent reaches minimum
// - zero exponent field means hidden integer bit is zero
// - fully shifted-out mantissa gives floating-point zero
// - gradual mode stalls one cycle per zero or denormal operand or non-compare result
// - four rounding directions: nearest even, zero, plus and minus infinity
// - each operation meets one-rounding error bounds
// - eight exception flags from inexact to unordered comparison
// - compares give ordered and unordered relations as branch conditions
// - flush mode replaces underflowed results by zero with no stall
// - exception flags sticky until software clears; result delivered anyway
// - reset rounding mode is nearest even
// - results computed exactly then rounded once
`timescale 1ns/1ps
module ifu_alu (
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire        start_i,
    input  wire [2:0]  op_i,
    input  wire [31:0] opa_i,
    input  wire [31:0] opb_i,
    input  wire [63:0] dbl_i,
    input  wire        mode_wr_i,
    input  wire [7:0]  mode_wdata_i,
    input  wire        exc_clr_i,
    input  wire [7:0]  exc_clr_mask_i,
    output wire        busy_o,
    output reg         done_o,
    output reg  [31:0] result_o,
    output reg  [63:0] dbl_o,
    output wire [7:0]  mode_control_reg_o,
    output wire [7:0]  exception_flags_reg_o,
    output wire [7:0]  condition_flags_reg_o
);
`include "ifu_regs.vh"
    localparam ST_IDLE  = 2'h0;
    localparam ST_STALL = 2'h1;
    localparam ST_DONE  = 2'h2;

    // Reset release through two flops
    reg rst_a_ff, rst_b_ff;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end
    wire rst_n = rst_b_ff;

    // Operand decode
    wire        sa, sb, za, zb, da, db, ia, ib, na, nb, sna, snb;
    wire [7:0]  ea, eb;
    wire [23:0] ma, mb;
    ifu_classify u_cla (.word_i(opa_i), .sign_o(sa), .exp_o(ea), .mant_o(ma),
        .zero_o(za), .denorm_o(da), .inf_o(ia), .nan_o(na), .snan_o(sna));
    ifu_classify u_clb (.word_i(opb_i), .sign_o(sb), .exp_o(eb), .mant_o(mb),
        .zero_o(zb), .denorm_o(db), .inf_o(ib), .nan_o(nb), .snan_o(snb));

    reg [7:0]  mode_ff, exc_ff, cc_ff;
    reg [1:0]  state_ff;
    reg [1:0]  stall_cnt_ff;
    reg [31:0] res_hold_ff;
    reg [7:0]  exc_hold_ff, cc_hold_ff;
    wire [1:0] rnd = mode_ff[`IFU_MR_RND_LO+1:`IFU_MR_RND_LO];
    wire       ftz = mode_ff[`IFU_MR_FTZ];

    // Round decision: exact value kept with guard and sticky, rounded once
    function rnd_up;
        input [1:0] m;
        input       s, lsb, g, r, st;
        begin
            case (m)
                `IFU_RND_NEAR: rnd_up = g & (r | st | lsb);
                `IFU_RND_ZERO: rnd_up = 1'b0;
                `IFU_RND_PINF: rnd_up = ~s & (g | r | st);
                `IFU_RND_MINF: rnd_up = s & (g | r | st);
                default:       rnd_up = 1'b0;
            endcase
        end
    endfunction

    // Exact datapath: signed exponent, 50-bit mantissa with sticky
    reg        r_s, eff_sub, r_zero_exact, r_nan, r_inf, r_ope, r_dz;
    reg [9:0]  shift;
    reg [49:0] big_a, big_b, sum;
    reg [47:0] prod;
    reg signed [11:0] r_e;
    reg [11:0] dn_amt;
    reg [49:0] norm;
    reg [26:0] pre;
    reg        stk, up, unf, ovf, inx;
    reg [24:0] rounded;
    reg [31:0] res;
    reg [7:0]  exc_new, cc_new;
    reg        lt, eq, un;
    integer    i, lz;
    always @* begin
        r_s = 1'b0; eff_sub = 1'b0; r_zero_exact = 1'b0; shift = 10'h000;
        big_a = 50'h0; big_b = 50'h0; sum = 50'h0; prod = 48'h0; r_e = 12'sh000;
        norm = 50'h0; pre = 27'h0; stk = 1'b0; up = 1'b0; unf = 1'b0; ovf = 1'b0;
        inx = 1'b0; rounded = 25'h0; res = 32'h0; exc_new = 8'h00; cc_new = 8'h00;
        lz = 0;
        dn_amt = 12'h000;
        r_nan = na | nb;
        r_inf = 1'b0; r_ope = sna | snb; r_dz = 1'b0;
        un = na | nb;
        eq = ~un & ((za & zb) | (opa_i == opb_i));
        lt = ~un & ~eq & ((sa & ~sb) | (sa == sb & ((opa_i[30:0] < opb_i[30:0]) ^ sa)));
        if (op_i == `IFU_OP_MUL) begin
            r_s = sa ^ sb;
            prod = ma * mb;
            norm = {prod, 2'b00};
            r_e = $signed({4'h0, ea}) + $signed({4'h0, eb}) - 12'sd126;
            r_inf = ia | ib;
            r_ope = r_ope | (ia & zb) | (ib & za);
            r_zero_exact = za | zb;
        end else begin
            eff_sub = sa ^ sb ^ (op_i == `IFU_OP_SUB);
            if ({ea, ma} >= {eb, mb}) begin
                shift = {2'b00, ea - eb};
                big_a = {1'b0, ma, 25'h0};
                big_b = {1'b0, mb, 25'h0};
                r_s = sa; r_e = $signed({4'h0, ea});
            end else begin
                shift = {2'b00, eb - ea};
                big_a = {1'b0, mb, 25'h0};
                big_b = {1'b0, ma, 25'h0};
                r_s = sb ^ (op_i == `IFU_OP_SUB); r_e = $signed({4'h0, eb});
            end
            stk = (shift > 10'd48) ? |big_b : |(big_b << (10'd50 - shift));
            big_b = (shift > 10'd48) ? 50'h0 : big_b >> shift;
            sum = eff_sub ? big_a - big_b - {49'h0, stk} : big_a + big_b;
            norm = sum;
            r_e = r_e + 12'sd1;
            r_inf = ia | ib;
            r_ope = r_ope | (ia & ib & eff_sub);
            r_zero_exact = (sum == 50'h0) & ~stk;
            if (r_zero_exact) r_s = (rnd == `IFU_RND_MINF) ? eff_sub : sa & ~eff_sub;
        end
        // Normalize to bit 49
        for (i = 0; i < 50; i = i + 1)
            if (norm[i]) lz = 49 - i;
        if (!r_zero_exact) begin
            norm = norm << lz;
            r_e = r_e - lz[11:0];
        end
        // Denormalize below the minimum exponent
        if (r_e < 12'sd1 && !r_zero_exact) begin
            unf = 1'b1;
            dn_amt = 12'sd1 - r_e;
            shift = (r_e < -12'sd40) ? 10'd50 : dn_amt[9:0];
            stk = stk | (shift > 10'd49 ? |norm : |(norm << (10'd50 - shift)));
            norm = (shift > 10'd49) ? 50'h0 : norm >> shift;
            r_e = 12'sd1;
        end
        pre = {norm[49:24], |norm[23:0] | stk};
        inx = pre[2] | pre[1] | pre[0];                                    // Guard, round or sticky
        up = rnd_up(rnd, r_s, pre[3], pre[2], pre[1], pre[0]);
        rounded = {1'b0, pre[26:3]} + {24'h0, up};
        if (rounded[24]) begin rounded = rounded >> 1; r_e = r_e + 12'sd1; end
        ovf = r_e > 12'sd254;
        if (r_nan | r_ope)
            res = `IFU_QNAN;
        else if (r_inf)
            res = {r_s, `IFU_SP_EXP_MAX, 23'h0};
        else if (ovf)
            res = (rnd == `IFU_RND_ZERO || (rnd == `IFU_RND_PINF && r_s) ||
                   (rnd == `IFU_RND_MINF && !r_s)) ? {r_s, 31'h7f7fffff}
                                                   : {r_s, `IFU_SP_EXP_MAX, 23'h0};
        else if (r_zero_exact || (unf && ftz) || rounded[23:0] == 24'h0)
            res = {r_s, 31'h0};
        else
            res = {r_s, rounded[23] ? r_e[7:0] : 8'h00, rounded[22:0]};
        unf = unf & inx;
        exc_new[`IFU_EX_INX]  = (inx | ovf) & ~r_nan & ~r_inf;
        exc_new[`IFU_EX_DZ]   = r_dz;
        exc_new[`IFU_EX_UNF]  = unf;
        exc_new[`IFU_EX_OVF]  = ovf & ~r_nan & ~r_inf;
        exc_new[`IFU_EX_OPE]  = r_ope;
        exc_new[`IFU_EX_SNAN] = sna | snb;
        exc_new[`IFU_EX_NAN]  = na | nb;
        exc_new[`IFU_EX_UNC]  = (op_i == `IFU_OP_CMP) & un;
        if (op_i == `IFU_OP_CMP) begin
            exc_new[`IFU_EX_INX] = 1'b0; exc_new[`IFU_EX_UNF] = 1'b0;
            exc_new[`IFU_EX_OVF] = 1'b0; exc_new[`IFU_EX_OPE] = sna | snb;
            res = opb_i;
        end
        cc_new[`IFU_CC_C]  = lt;
        cc_new[`IFU_CC_V]  = exc_new[`IFU_EX_OVF];
        cc_new[`IFU_CC_Z]  = (op_i == `IFU_OP_CMP) ? eq : res[30:0] == 31'h0;
        cc_new[`IFU_CC_N]  = (op_i == `IFU_OP_CMP) ? lt : res[`IFU_SP_SIGN];
        cc_new[`IFU_CC_I]  = res[30:0] == {`IFU_SP_EXP_MAX, 23'h0};
        cc_new[`IFU_CC_LR] = un;
        cc_new[`IFU_CC_R]  = un;
        cc_new[`IFU_CC_A]  = ~un;
    end

    // Result denormal or zero check for the stall count
    wire res_den = (res[30:23] == 8'h00);
    wire [1:0] nxt_stall = ftz ? 2'h0 :
        {1'b0, da & (op_i != `IFU_OP_MOVD)} + {1'b0, db & (op_i != `IFU_OP_MOVD)}
        + {1'b0, res_den & (op_i != `IFU_OP_CMP) & (op_i != `IFU_OP_MOVD)};

    assign busy_o = (state_ff == ST_STALL);
    assign mode_control_reg_o    = mode_ff;
    assign exception_flags_reg_o = exc_ff;
    assign condition_flags_reg_o = cc_ff;

    // Sequencer, mode, sticky flags and condition codes; synchronised reset
    always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE; stall_cnt_ff <= 2'h0; done_o <= 1'b0;
            result_o <= 32'h0; dbl_o <= 64'h0; res_hold_ff <= 32'h0;
            exc_hold_ff <= 8'h00; cc_hold_ff <= 8'h00;
            mode_ff <= `IFU_MR_RESET; exc_ff <= 8'h00; cc_ff <= 8'h00;
        end else begin
            done_o <= 1'b0;
            if (mode_wr_i) mode_ff <= mode_wdata_i & `IFU_MR_MASK;
            // Set wins over clear
            exc_ff <= exc_ff & ~(exc_clr_i ? exc_clr_mask_i : 8'h00);
            case (state_ff)
                ST_IDLE: begin
                    if (start_i && op_i == `IFU_OP_MOVD) begin
                        dbl_o <= dbl_i;
                        done_o <= 1'b1;
                    end else if (start_i) begin
                        res_hold_ff <= res; exc_hold_ff <= exc_new; cc_hold_ff <= cc_new;
                        if (nxt_stall == 2'h0) begin
                            result_o <= res; done_o <= 1'b1; cc_ff <= cc_new;
                            exc_ff <= (exc_ff & ~(exc_clr_i ? exc_clr_mask_i : 8'h00))
                                      | exc_new;
                        end else begin
                            stall_cnt_ff <= nxt_stall;
                            state_ff <= ST_STALL;
                        end
                    end
                end
                ST_STALL: begin
                    stall_cnt_ff <= stall_cnt_ff - 2'h1;
                    if (stall_cnt_ff == 2'h1) state_ff <= ST_DONE;
                end
                ST_DONE: begin
                    result_o <= res_hold_ff; done_o <= 1'b1; cc_ff <= cc_hold_ff;
                    exc_ff <= (exc_ff & ~(exc_clr_i ? exc_clr_mask_i : 8'h00))
                              | exc_hold_ff;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- hw/ifu_regs.vh
// Constants for the float format and underflow unit
`ifndef IFU_REGS_VH
`define IFU_REGS_VH
`define IFU_SP_SIGN      31
`define IFU_SP_EXP_HI    30
`define IFU_SP_EXP_LO    23
`define IFU_SP_FRAC_HI   22
`define IFU_SP_BIAS      8'h7f
`define IFU_SP_EXP_MAX   8'hff
`define IFU_DP_SIGN      63
`define IFU_DP_EXP_HI    62
`define IFU_DP_EXP_LO    52
`define IFU_DP_FRAC_HI   51
`define IFU_DP_BIAS      11'h3ff
`define IFU_RND_NEAR     2'h0
`define IFU_RND_ZERO     2'h1
`define IFU_RND_PINF     2'h2
`define IFU_RND_MINF     2'h3
`define IFU_OP_ADD       3'h0
`define IFU_OP_SUB       3'h1
`define IFU_OP_MUL       3'h2
`define IFU_OP_CMP       3'h3
`define IFU_OP_MOVD      3'h4
`define IFU_EX_INX       0
`define IFU_EX_DZ        1
`define IFU_EX_UNF       2
`define IFU_EX_OVF       3
`define IFU_EX_OPE       4
`define IFU_EX_SNAN      5
`define IFU_EX_NAN       6
`define IFU_EX_UNC       7
`define IFU_CC_C         0
`define IFU_CC_V         1
`define IFU_CC_Z         2
`define IFU_CC_N         3
`define IFU_CC_I         4
`define IFU_CC_LR        5
`define IFU_CC_R         6
`define IFU_CC_A         7
`define IFU_MR_RND_LO    0
`define IFU_MR_FTZ       2
`define IFU_MR_MASK      8'h07
`define IFU_MR_RESET     8'h00
`define IFU_QNAN         32'h7fc00000
`endif

//--- hw/ifu_classify.v
// Operand classifier for single precision storage words
`timescale 1ns/1ps
module ifu_classify (
    input  wire [31:0] word_i,
    output wire        sign_o,
    output wire [7:0]  exp_o,
    output wire [23:0] mant_o,
    output wire        zero_o,
    output wire        denorm_o,
    output wire        inf_o,
    output wire        nan_o,
    output wire        snan_o
);
`include "ifu_regs.vh"
    // Field split and special value decode
    wire [7:0] raw_exp = word_i[`IFU_SP_EXP_HI:`IFU_SP_EXP_LO];
    wire       efull   = (raw_exp == `IFU_SP_EXP_MAX);
    wire       ezero   = (raw_exp == 8'h00);
    wire       fz      = (word_i[`IFU_SP_FRAC_HI:0] == 23'h000000);
    assign sign_o   = word_i[`IFU_SP_SIGN];
    assign exp_o    = ezero ? 8'h01 : raw_exp;        // Denormals sit at minimum
    assign mant_o   = {~ezero, word_i[`IFU_SP_FRAC_HI:0]}; // Hidden bit 0 if exp 0
    assign zero_o   = ezero & fz;
    assign denorm_o = ezero;                         // Zero counted as well
    assign inf_o    = efull & fz;
    assign nan_o    = efull & ~fz;
    assign snan_o   = efull & ~fz & ~word_i[`IFU_SP_FRAC_HI];
endmodule

//--- test/ifu_seq_model.sv
// Sequencer model that issues ALU requests and times the answer
`timescale 1ns/1ps
module ifu_seq_model (
    input  wire         mclk_i,
    input  wire         done_i,
    output logic        start_o,
    output logic [2:0]  op_o,
    output logic [31:0] opa_o,
    output logic [31:0] opb_o,
    output logic [63:0] dbl_o
);
    // Idle request lines from time zero
    initial begin
        start_o = 1'b0;
        op_o    = 3'h0;
        opa_o   = 32'h0;
        opb_o   = 32'h0;
        dbl_o   = 64'h0;
    end

    // Hold request to its taking edge, then scramble the operands
    task automatic issue(input logic [2:0] op, input logic [31:0] a, b,
                         input logic [63:0] d, output int lat);
        int i;
        @(posedge mclk_i);
        start_o <= 1'b1;
        op_o    <= op;
        opa_o   <= a;
        opb_o   <= b;
        dbl_o   <= d;
        @(posedge mclk_i);
        start_o <= 1'b0;
        opa_o   <= ~a;
        opb_o   <= ~b;
        dbl_o   <= ~d;
        lat = 0;
        // Bounded wait for the answer
        for (i = 1; i <= 12 && lat == 0; i++) begin
            #1;
            if (done_i === 1'b1)
                lat = i;
            else
                @(posedge mclk_i);
        end
    endtask
endmodule

//--- test/ifu_alu_assertions.sv
// Concurrent checks on the float ALU ports
`timescale 1ns/1ps
`include "ifu_regs.vh"
module ifu_alu_checker (
    input logic        mclk_i,
    input logic        reset_n_i,
    input logic        start_i,
    input logic [2:0]  op_i,
    input logic [63:0] dbl_i,
    input logic        mode_wr_i,
    input logic [7:0]  mode_wdata_i,
    input logic        exc_clr_i,
    input logic [7:0]  exc_clr_mask_i,
    input logic        busy_o,
    input logic        done_o,
    input logic [31:0] result_o,
    input logic [63:0] dbl_o,
    input logic [7:0]  mode_control_reg_o,
    input logic [7:0]  exception_flags_reg_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // Timing of moves and stalls
    a_move_one_cycle: assert property (
        start_i && !busy_o && !$past(busy_o) && op_i == `IFU_OP_MOVD
        |=> done_o && dbl_o == $past(dbl_i)) else $error("move answer wrong");
    a_stall_bounded: assert property (
        $rose(busy_o) |-> ##[1:3] !busy_o) else $error("stall too long");
    a_stall_then_done: assert property (
        $fell(busy_o) |=> done_o) else $error("no answer after stall");
    a_result_holds: assert property (
        !done_o |-> $stable(result_o)) else $error("result moved without answer");

    // Mode and flag registers
    a_mode_write: assert property (
        mode_wr_i |=> mode_control_reg_o == ($past(mode_wdata_i) & `IFU_MR_MASK))
        else $error("mode write wrong");
    a_mode_reserved: assert property (
        mode_control_reg_o[7:3] == 5'h00) else $error("reserved mode bits set");
    a_exc_clear: assert property (
        exc_clr_i |=> done_o || (exception_flags_reg_o & $past(exc_clr_mask_i)) == 8'h00)
        else $error("flag clear failed");
    a_flags_sticky: assert property (
        ($past(exception_flags_reg_o) & ~exception_flags_reg_o
         & ~({8{$past(exc_clr_i)}} & $past(exc_clr_mask_i))) == 8'h00)
        else $error("flag dropped without clear");

    // Main scenarios reached
    c_stall: cover property ($rose(busy_o));
    c_flush: cover property (done_o && mode_control_reg_o[2]);
    c_clear: cover property (exc_clr_i);
endmodule

bind ifu_alu ifu_alu_checker chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .start_i(start_i), .op_i(op_i),
    .dbl_i(dbl_i), .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i),
    .exc_clr_i(exc_clr_i), .exc_clr_mask_i(exc_clr_mask_i), .busy_o(busy_o),
    .done_o(done_o), .result_o(result_o), .dbl_o(dbl_o),
    .mode_control_reg_o(mode_control_reg_o),
    .exception_flags_reg_o(exception_flags_reg_o)
);

//--- test/tb.sv
// Self-checking bench for the float ALU
`timescale 1ns/1ps
`include "ifu_regs.vh"
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
end
module tb;
    logic        mclk_i;
    logic        reset_n_i;
    logic        mode_wr_i;
    logic [7:0]  mode_wdata_i;
    logic        exc_clr_i;
    logic [7:0]  exc_clr_mask_i;
    wire         start_i;
    wire  [2:0]  op_i;
    wire  [31:0] opa_i;
    wire  [31:0] opb_i;
    wire  [63:0] dbl_i;
    wire         busy_o;
    wire         done_o;
    wire  [31:0] result_o;
    wire  [63:0] dbl_o;
    wire  [7:0]  mode_o;
    wire  [7:0]  exc_o;
    wire  [7:0]  cc_o;
    int          miscompares;
    int          comparisons;
    int          lat;

    ifu_alu uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .start_i(start_i), .op_i(op_i),
        .opa_i(opa_i), .opb_i(opb_i), .dbl_i(dbl_i), .mode_wr_i(mode_wr_i),
        .mode_wdata_i(mode_wdata_i), .exc_clr_i(exc_clr_i), .exc_clr_mask_i(exc_clr_mask_i),
        .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .dbl_o(dbl_o),
        .mode_control_reg_o(mode_o), .exception_flags_reg_o(exc_o),
        .condition_flags_reg_o(cc_o));
    ifu_seq_model seq (.mclk_i(mclk_i), .done_i(done_o), .start_o(start_i), .op_o(op_i),
        .opa_o(opa_i), .opb_o(opb_i), .dbl_o(dbl_i));

    // Verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One request, answer time checked, hang cut short
    task automatic run(input logic [2:0] op, input logic [31:0] a, b, input int el);
        seq.issue(op, a, b, 64'h0, lat);
        `CHK("latency", el, lat)
        if (lat == 0)
            wrap_up();
    endtask

    // Mode write and flag clear pulses
    task automatic set_mode(input logic [7:0] v);
        @(posedge mclk_i);
        mode_wr_i    <= 1'b1;
        mode_wdata_i <= v;
        @(posedge mclk_i);
        mode_wr_i <= 1'b0;
        #1;
    endtask
    task automatic clear_exc(input logic [7:0] m);
        @(posedge mclk_i);
        exc_clr_i      <= 1'b1;
        exc_clr_mask_i <= m;
        @(posedge mclk_i);
        exc_clr_i <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        `CHK("mode", 8'h00, mode_o)
        `CHK("flags", 8'h00, exc_o)
        set_mode(8'hff);
        `CHK("mode rsvd", 8'h07, mode_o)
        set_mode(8'h00);
        $display("test reset done");
    endtask

    task automatic t_arith();
        run(`IFU_OP_ADD, 32'h3f800000, 32'h3f800000, 1);
        `CHK("sum", 32'h40000000, result_o)
        run(`IFU_OP_ADD, 32'h3f800000, 32'h33800000, 1);
        `CHK("tie even", 32'h3f800000, result_o)
        `CHK("inexact", 1'b1, exc_o[0])
        run(`IFU_OP_SUB, 32'h3f800000, 32'h3f800000, 3);
        `CHK("diff", 32'h00000000, result_o)
        `CHK("zero cc", 1'b1, cc_o[2])
        run(`IFU_OP_ADD, 32'h00000001, 32'h00000001, 5);
        `CHK("dn sum", 32'h00000002, result_o)
        run(`IFU_OP_MUL, 32'h7f000000, 32'h40000000, 1);
        `CHK("ovf", 32'h7f800000, result_o)
        `CHK("ovf flag", 1'b1, exc_o[3])
        `CHK("ovf cc", 2'b11, {cc_o[4], cc_o[1]})
        run(`IFU_OP_ADD, 32'h7f800001, 32'h3f800000, 1);
        `CHK("snan flag", 1'b1, exc_o[5])
        `CHK("operr flag", 1'b1, exc_o[4])
        `CHK("qnan", 9'h1ff, result_o[30:22])
        $display("test arith done");
    endtask

    task automatic t_under();
        logic [31:0] want [8] = '{32'h2, 32'h80000002, 32'h1, 32'h80000001,
                                  32'h2, 32'h80000001, 32'h1, 32'h80000002};
        int i;
        clear_exc(8'hff);
        run(`IFU_OP_MUL, 32'h00800000, 32'h3f000000, 3);
        `CHK("denorm", 32'h00400000, result_o)
        `CHK("exact unf", 1'b0, exc_o[2])
        run(`IFU_OP_MUL, 32'h00000001, 32'h3f000000, 4);
        `CHK("to zero", 32'h00000000, result_o)
        `CHK("unf flag", 1'b1, exc_o[2])
        // Each direction on a positive and a negative tie
        for (i = 0; i < 8; i++) begin
            set_mode({6'h00, i[2:1]});
            run(`IFU_OP_MUL, 32'h00000003, {i[0], 31'h3f000000}, 4);
            `CHK("rounded", want[i], result_o)
        end
        set_mode(8'h04);
        run(`IFU_OP_MUL, 32'h00000003, 32'h3f000000, 1);
        `CHK("flushed", 32'h00000000, result_o)
        set_mode(8'h00);
        run(`IFU_OP_ADD, 32'h3f800000, 32'h3f800000, 1);
        `CHK("sticky", 1'b1, exc_o[2])
        clear_exc(8'h01);
        `CHK("cleared", 2'b10, {exc_o[2], exc_o[0]})
        $display("test underflow done");
    endtask

    task automatic t_cmp_move();
        run(`IFU_OP_CMP, 32'h3f800000, 32'h40000000, 1);
        `CHK("cmp res", 32'h40000000, result_o)
        `CHK("cmp cc", 5'b10101, {cc_o[7], cc_o[6], cc_o[3], cc_o[2], cc_o[0]})
        run(`IFU_OP_CMP, 32'h7fc00000, 32'h3f800000, 1);
        `CHK("unord cc", 2'b01, {cc_o[7], cc_o[6]})
        `CHK("unord flag", 1'b1, exc_o[7])
        `CHK("nan flag", 1'b1, exc_o[6])
        `CHK("lrej cc", 1'b1, cc_o[5])
        seq.issue(`IFU_OP_MOVD, 32'h0, 32'h0, 64'hc00921fb54442d18, lat);
        `CHK("move lat", 1, lat)
        `CHK("move", 64'hc00921fb54442d18, dbl_o)
        $display("test compare and move done");
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // Reset, then the scenarios in turn
    initial begin
        reset_n_i      = 1'b0;
        mode_wr_i      = 1'b0;
        mode_wdata_i   = 8'h00;
        exc_clr_i      = 1'b0;
        exc_clr_mask_i = 8'h00;
        miscompares    = 0;
        comparisons    = 0;
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        t_reset();
        t_arith();
        t_under();
        t_cmp_move();
        wrap_up();
    end
endmodule
